/* File: design/chan_enable_params.svh */
// constants for the channel enable latch block: offsets, reset values, bit maps
`ifndef CHAN_ENABLE_PARAMS_SVH
`define CHAN_ENABLE_PARAMS_SVH

// apb byte offsets
`define REG_LATCH_STATE   8'h00
`define REG_FAULT_STATE   8'h04
`define REG_EVENT_STATUS  8'h08
`define REG_EVENT_MASK    8'h0c

// latch clear values under device reset
`define SELFTEST_CLEAR    8'hff
`define DRIVER_EN_CLEAR   8'h00
`define RX_POWER_CLEAR    4'h0

// default bus bit maps, three bits per channel, channel a lowest
`define TX_SELFTEST_MAP   12'hd10
`define RX_SELFTEST_MAP   12'hf59
`define RX_POWER_MAP      12'hd10

// register field positions
`define LS_SELFTEST_LSB   0
`define LS_DRIVER_LSB     8
`define LS_RX_POWER_LSB   16
`define EV_FAULT_LSB      0
`define EV_CLOSE_LSB      4

`endif

/* File: design/chan_enable_pkg.sv */
// types shared by the channel enable latch block
package chan_enable_pkg;

    typedef struct packed {
        logic [3:0] freq_out_of_range;
        logic [3:0] amplitude_low;
        logic [3:0] density_low;
    } rx_fault_in_t;

    typedef struct packed {
        logic [3:0] tx_selftest_n;
        logic [3:0] rx_selftest_n;
        logic [7:0] serial_output_driver_en;
        logic [3:0] rx_power_en;
    } chan_cfg_t;

    typedef enum logic [1:0] {
        LATCH_SELFTEST = 2'b00,
        LATCH_RX_POWER = 2'b01,
        LATCH_DRIVER   = 2'b10
    } latch_id_t;

endpackage : chan_enable_pkg

/* File: design/channel_enable_latches.sv */
// three enable-bus latches, link fault outputs, apb status and interrupt
`timescale 1ns/1ps
`include "chan_enable_params.svh"

// Behaviour
// - open selftest latch follows enable bus
// - low selftest bit selects sequence generate/check
// - closing selftest latch holds bus value
// - device reset clears closed selftest latch
// - open rx power latch follows bus
// - high power bit keeps rx analog active
// - closing rx power latch retains value
// - device reset low disables all receivers
// - driver latch passes bus, captures on close
// - each latch follows only its opener
// - link fault low on any condition
// - four conditions including receiver disabled
// - high driver bit enables serial driver
// - device reset disables all serial drivers
module channel_enable_latches
    import chan_enable_pkg::*;
#(
    parameter logic [11:0] TX_SELFTEST_MAP = `TX_SELFTEST_MAP,
    parameter logic [11:0] RX_SELFTEST_MAP = `RX_SELFTEST_MAP,
    parameter logic [11:0] RX_POWER_MAP    = `RX_POWER_MAP
)
(
    // apb
    input  wire  logic          pclk,
    input  wire  logic          presetn,
    input  wire  logic          psel,
    input  wire  logic          penable,
    input  wire  logic          pwrite,
    input  wire  logic [7:0]    paddr,
    input  wire  logic [31:0]   pwdata,
    output logic                pready,
    output logic                pslverr,
    output logic [31:0]         prdata,
    // configuration pins
    input  wire  logic          device_reset_n,
    input  wire  logic [7:0]    shared_enable_bus,
    input  wire  logic          selftest_latch_open,
    input  wire  logic          rx_power_latch_open,
    input  wire  logic          driver_enable_latch_open,
    // receive fault conditions
    input  wire  rx_fault_in_t  rx_fault,
    // channel configuration and indications
    output chan_cfg_t           cfg,
    output logic [3:0]          link_fault_n,
    output logic                irq
);

    ////////////////////////////////////////////////////////////////////////
    // bus bit mapping

    logic [3:0] tx_st_bus;
    logic [3:0] rx_st_bus;
    logic [3:0] rx_pw_bus;

    for (genvar c = 0; c < 4; c++)
    begin : g_map
        assign tx_st_bus[c] = shared_enable_bus[TX_SELFTEST_MAP[3*c +: 3]];
        assign rx_st_bus[c] = shared_enable_bus[RX_SELFTEST_MAP[3*c +: 3]];
        assign rx_pw_bus[c] = shared_enable_bus[RX_POWER_MAP[3*c +: 3]];
    end

    ////////////////////////////////////////////////////////////////////////
    // latches: a latch samples the bus on every edge while open and not overridden by device reset, and keeps
    // its value once closed until device reset; this costs one cycle of lag against a true latch

    chan_cfg_t cfg_r;
    chan_cfg_t cfg_nxt;
    logic [2:0] open_q_r;
    logic [2:0] open_q_nxt;
    logic [2:0] opens;

    assign opens[LATCH_SELFTEST] = selftest_latch_open;
    assign opens[LATCH_RX_POWER] = rx_power_latch_open;
    assign opens[LATCH_DRIVER]   = driver_enable_latch_open;

    always_comb
    begin
        cfg_nxt = cfg_r;
        open_q_nxt = opens;
        if (selftest_latch_open)
        begin
            cfg_nxt.tx_selftest_n = tx_st_bus;
            cfg_nxt.rx_selftest_n = rx_st_bus;
        end
        else if (!device_reset_n)
        begin
            // only a closed latch is cleared; while open the bus keeps control
            {cfg_nxt.tx_selftest_n, cfg_nxt.rx_selftest_n} = `SELFTEST_CLEAR;
        end
        // closed and not reset, value held by default
        if (!device_reset_n)
            cfg_nxt.rx_power_en = `RX_POWER_CLEAR;
        else if (rx_power_latch_open)
            cfg_nxt.rx_power_en = rx_pw_bus;
        if (!device_reset_n)
            cfg_nxt.serial_output_driver_en = `DRIVER_EN_CLEAR;
        else if (driver_enable_latch_open)
            cfg_nxt.serial_output_driver_en = shared_enable_bus;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_r <= {`SELFTEST_CLEAR, `DRIVER_EN_CLEAR, `RX_POWER_CLEAR};
            open_q_r <= 3'h0;
        end
        else
        begin
            cfg_r <= cfg_nxt;
            open_q_r <= open_q_nxt;
        end
    end

    assign cfg = cfg_r;

    ////////////////////////////////////////////////////////////////////////
    // link fault indication

    logic [3:0] fault_r;
    logic [3:0] fault_nxt;

    always_comb
    begin
        fault_nxt = rx_fault.freq_out_of_range
                  | rx_fault.amplitude_low
                  | rx_fault.density_low
                  | ~cfg_r.rx_power_en;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fault_r <= 4'hf;
        else
            fault_r <= fault_nxt;
    end

    assign link_fault_n = ~fault_r;

    ////////////////////////////////////////////////////////////////////////
    // apb slave, sticky events and interrupt

    logic [6:0]  evt_r;
    logic [6:0]  evt_nxt;
    logic [6:0]  mask_r;
    logic [6:0]  mask_nxt;
    logic [31:0] prdata_r;
    logic [31:0] prdata_nxt;
    logic [6:0]  events;
    logic        setup;
    logic        access;
    logic        mapped;

    // fault rising per channel, and each latch closing
    assign events = {open_q_r & ~opens, fault_nxt & ~fault_r};

    assign setup  = psel & ~penable;
    assign access = psel & penable;
    assign mapped = (paddr == `REG_LATCH_STATE) || (paddr == `REG_FAULT_STATE)
                 || (paddr == `REG_EVENT_STATUS) || (paddr == `REG_EVENT_MASK);

    assign pready  = 1'b1;
    assign pslverr = access & ~mapped;

    always_comb
    begin
        prdata_nxt = prdata_r;
        mask_nxt = mask_r;
        evt_nxt = evt_r;
        if (setup)
        begin
            prdata_nxt = 32'h0;
            if (!pwrite)
            begin
                case (paddr)
                    `REG_LATCH_STATE:
                    begin
                        prdata_nxt[`LS_SELFTEST_LSB +: 8] = {cfg_r.rx_selftest_n, cfg_r.tx_selftest_n};
                        prdata_nxt[`LS_DRIVER_LSB +: 8] = cfg_r.serial_output_driver_en;
                        prdata_nxt[`LS_RX_POWER_LSB +: 4] = cfg_r.rx_power_en;
                    end
                    `REG_FAULT_STATE:  prdata_nxt[3:0] = fault_r;
                    `REG_EVENT_STATUS: prdata_nxt[6:0] = evt_r;
                    `REG_EVENT_MASK:   prdata_nxt[6:0] = mask_r;
                    default:           prdata_nxt = 32'h0;
                endcase
            end
        end
        // a read clears only the bits it reported; new events win
        if (access && !pwrite && paddr == `REG_EVENT_STATUS)
            evt_nxt = evt_nxt & ~prdata_r[6:0];
        evt_nxt = evt_nxt | events;
        if (access && pwrite && paddr == `REG_EVENT_MASK)
            mask_nxt = pwdata[6:0];
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_r <= 32'h0;
            mask_r <= 7'h00;
            evt_r <= 7'h00;
        end
        else
        begin
            prdata_r <= prdata_nxt;
            mask_r <= mask_nxt;
            evt_r <= evt_nxt;
        end
    end

    assign prdata = prdata_r;
    assign irq = |(evt_r & mask_r);

endmodule : channel_enable_latches

/* File: tb/cel_host.sv */
// host model driving the enable bus, latch openers and device reset
`timescale 1ns/1ps
module cel_host
    import chan_enable_pkg::*;
(
    // clock
    input  wire logic  clk,
    // pins
    output logic [7:0] bus,
    output logic [2:0] open,
    output logic       dev_rst_n
);
    initial {bus, open, dev_rst_n} = 12'h001;
    // bus flips after close so a leaky latch shows
    task automatic load(input latch_id_t id, input logic [7:0] v);
    begin
        @(posedge clk);
        bus <= v;
        open[id] <= 1'b1;
        @(posedge clk);
        open[id] <= 1'b0;
        bus <= ~v;
    end
    endtask : load
    task automatic pulse_reset;
    begin
        @(posedge clk);
        dev_rst_n <= 1'b0;
        @(posedge clk);
        dev_rst_n <= 1'b1;
    end
    endtask : pulse_reset
endmodule : cel_host

/* File: tb/channel_enable_latches_chk.sv */
// port checks for the channel enable latches
`timescale 1ns/1ps
module channel_enable_latches_chk
    import chan_enable_pkg::*;
(
    // clock and resets
    input wire logic         pclk,
    input wire logic         presetn,
    input wire logic         device_reset_n,
    // pins
    input wire logic [7:0]   shared_enable_bus,
    input wire logic         selftest_latch_open,
    input wire logic         rx_power_latch_open,
    input wire logic         driver_enable_latch_open,
    input wire rx_fault_in_t rx_fault,
    input wire chan_cfg_t    cfg,
    input wire logic [3:0]   link_fault_n
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    // bench map: even bits to tx selftest and rx power, odd to rx selftest
    wire logic [3:0] ev = {shared_enable_bus[6], shared_enable_bus[4], shared_enable_bus[2], shared_enable_bus[0]};
    wire logic [3:0] od = {shared_enable_bus[7], shared_enable_bus[5], shared_enable_bus[3], shared_enable_bus[1]};
    wire logic [3:0] bad = rx_fault.freq_out_of_range | rx_fault.amplitude_low | rx_fault.density_low;
    chk_st_follow: assert property (selftest_latch_open |=>
        cfg.tx_selftest_n == $past(ev) && cfg.rx_selftest_n == $past(od)) else $error("selftest not following");
    chk_st_hold: assert property (!selftest_latch_open && device_reset_n |=> $stable(cfg[19:12]))
        else $error("selftest latch leaked");
    chk_st_clear: assert property (!selftest_latch_open && !device_reset_n |=> cfg[19:12] == 8'hff)
        else $error("selftest not cleared");
    chk_rx_follow: assert property (rx_power_latch_open && device_reset_n |=> cfg.rx_power_en == $past(ev))
        else $error("rx power not following");
    chk_rx_hold: assert property (!rx_power_latch_open && device_reset_n |=> $stable(cfg.rx_power_en))
        else $error("rx power latch leaked");
    chk_reset_off: assert property (!device_reset_n |=> cfg.rx_power_en == 4'h0 && cfg[11:4] == 8'h00)
        else $error("reset left channels on");
    chk_drv_follow: assert property (driver_enable_latch_open && device_reset_n |=>
        cfg.serial_output_driver_en == $past(shared_enable_bus)) else $error("driver latch not following");
    chk_fault_or: assert property (link_fault_n == ~($past(bad) | ~$past(cfg.rx_power_en)))
        else $error("link fault wrong");
    cover property (selftest_latch_open ##1 !selftest_latch_open);
    cover property (!device_reset_n);
    cover property (link_fault_n != 4'h0);
endmodule : channel_enable_latches_chk
bind channel_enable_latches channel_enable_latches_chk chk_i (.pclk, .presetn, .device_reset_n,
    .shared_enable_bus, .selftest_latch_open, .rx_power_latch_open, .driver_enable_latch_open,
    .rx_fault, .cfg, .link_fault_n);

/* File: tb/channel_enable_latches_tb_top.sv */
// self-checking bench for the channel enable latches
`timescale 1ns/1ps
module channel_enable_latches_tb_top
    import chan_enable_pkg::*;
;
    logic         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0]   paddr = 8'h00, bus;
    logic [31:0]  pwdata = 32'h0, prdata, rd;
    logic         pready, pslverr, err, irq, dev_rst_n;
    logic [2:0]   op;
    logic [3:0]   lfn;
    rx_fault_in_t flt = '0;
    chan_cfg_t    cfg;
    int           mismatches = 0, total_checks = 0, cycles = 0;
    always #12.5 pclk = ~pclk;
    cel_host cel_host_i (.clk(pclk), .bus, .open(op), .dev_rst_n);
    channel_enable_latches #(.TX_SELFTEST_MAP(12'hd10), .RX_SELFTEST_MAP(12'hf59), .RX_POWER_MAP(12'hd10))
        channel_enable_latches_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
        .prdata, .device_reset_n(dev_rst_n), .shared_enable_bus(bus), .selftest_latch_open(op[0]),
        .rx_power_latch_open(op[1]), .driver_enable_latch_open(op[2]), .rx_fault(flt), .cfg, .link_fault_n(lfn),
        .irq);
    function automatic logic [3:0] ev(input logic [7:0] b);
        return {b[6], b[4], b[2], b[0]};
    endfunction : ev
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    begin
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", what, exp, seen);
        end
    end
    endtask : check
    task automatic stop_test;
    begin
        if (mismatches == 0 && total_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask : stop_test
    always @(posedge pclk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            mismatches++;
            stop_test();
        end
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    begin
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'b00;
    end
    endtask : apb
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_driver;
    begin
        cel_host_i.load(LATCH_DRIVER, 8'ha5);
        @(negedge pclk);
        check("drv", cfg.serial_output_driver_en, 8'ha5);
    end
    endtask : t_driver
    task automatic t_selftest;
    begin
        cel_host_i.load(LATCH_SELFTEST, 8'h36);
        @(negedge pclk);
        check("st", cfg[19:12], {ev(8'h36), ev(8'h1b)});
        repeat (2) @(negedge pclk);
        check("st_hold", cfg[19:4], {ev(8'h36), ev(8'h1b), 8'ha5});
        cel_host_i.pulse_reset();
        @(negedge pclk);
        check("st_clr", cfg[19:12], 8'hff);
    end
    endtask : t_selftest
    task automatic t_rx_power;
    begin
        cel_host_i.load(LATCH_RX_POWER, 8'h11);
        repeat (3) @(negedge pclk);
        check("rxp", cfg.rx_power_en, 4'h5);
        check("lfn", lfn, 4'h5);
        for (int i = 0; i < 3; i++)
        begin
            @(posedge pclk) flt <= 12'h001 << (4 * i);
            repeat (2) @(negedge pclk);
            check("lfn_f", lfn, 4'h4);
            @(posedge pclk) flt <= '0;
        end
        cel_host_i.pulse_reset();
        @(negedge pclk);
        check("rst_off", {cfg.rx_power_en, cfg.serial_output_driver_en}, 12'h000);
    end
    endtask : t_rx_power
    task automatic t_apb;
    begin
        apb(1'b0, 8'h0c, 32'h0);
        check("mask0", rd, 32'h0);
        apb(1'b1, 8'h0c, 32'h7f);
        @(negedge pclk);
        check("irq", irq, 1'b1);
        apb(1'b0, 8'h08, 32'h0);
        check("ev_close", rd[6:4], 3'b111);
        apb(1'b0, 8'h08, 32'h0);
        @(negedge pclk);
        check("ev_clr", rd, 32'h0);
        check("irq_clr", irq, 1'b0);
        apb(1'b0, 8'h40, 32'h0);
        check("unmap", err, 1'b1);
    end
    endtask : t_apb
    initial
    begin
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        t_driver();
        t_selftest();
        t_rx_power();
        t_apb();
        stop_test();
    end
endmodule : channel_enable_latches_tb_top
